// *** rtl/serial_segment_display_driver.sv ***
// serial-in segment display driver with latches and backplane generation
// Operation
// - shift data on falling clock while selected
// - load rising copies shift register to latches
// - latches transparent while load stays high
// - latched one drives segment opposite backplane
// - external reference gives in-phase backplane
// - internal oscillator divided by 256
// - latches hold until next load
// - up to 38 segment outputs
// - length option 30/32/38, data out last
// - static drive holds backplane constant
`timescale 1ns/100ps
`include "seg_driver_defines.svh"
module serial_segment_display_driver (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic data_in,
  input wire logic chip_sel_n,
  input wire logic load,
  input wire logic backplane_ref_in,
  input wire logic oscillator_option_pin,
  input wire seg_driver_pkg::bp_source_e bp_source,
  input wire seg_driver_pkg::chain_len_e chain_len,
  input wire logic bp_static_level,
  output logic data_out,
  output logic backplane_out,
  output seg_driver_pkg::seg_word_t segments
);
  import seg_driver_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // link domain: shift register on falling shift_clk, no reset exists
  seg_word_t shift_r;
  seg_word_t shift_nxt;

  // stage 0 takes the serial input, every other stage its lower neighbour
  assign shift_nxt[0] = data_in;
  for (genvar i = 1; i < `SEG_MAX_STAGES; i++) begin : g_stage
    assign shift_nxt[i] = shift_r[i-1];
  end

  always_ff @(negedge shift_clk) begin
    if (!chip_sel_n) begin
      shift_r <= shift_nxt;
    end
  end

  // last stage of the chosen length
  always_comb begin
    case (chain_len)
      LEN_30: data_out = shift_r[`SEG_LEN_30-1];
      LEN_32: data_out = shift_r[`SEG_LEN_32-1];
      LEN_38: data_out = shift_r[`SEG_LEN_38-1];
      default: data_out = shift_r[`SEG_LEN_38-1];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing: a falling shift_clk is seen after two flops, then shift_r is read;
  // the link keeps shift_r still for a whole link period after each fall,
  // and the link side needs no reset to make this work
  logic clk_sync;
  logic clk_prev_r;
  logic sel_sync_n;
  logic load_sync;
  logic ref_sync;
  logic osc_sync;
  logic lvl_sync;
  logic load_prev_r;
  logic osc_prev_r;

  seg_sync2 u_clk_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(shift_clk),
    .sync_out(clk_sync)
  );
  // same depth as the clock path, so select and edge stay aligned
  seg_sync2 u_sel_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(chip_sel_n),
    .sync_out(sel_sync_n)
  );
  seg_sync2 u_load_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(load),
    .sync_out(load_sync)
  );
  seg_sync2 u_ref_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(backplane_ref_in),
    .sync_out(ref_sync)
  );
  seg_sync2 u_osc_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(oscillator_option_pin),
    .sync_out(osc_sync)
  );

  seg_sync2 u_lvl_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(bp_static_level),
    .sync_out(lvl_sync)
  );

  // only a selected fall publishes a word; reset values give no false edge
  logic new_word;
  assign new_word = clk_prev_r & ~clk_sync & ~sel_sync_n;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer of shifted words, drained into the mirror register
  logic buf_in_ready;
  logic buf_out_valid;
  seg_word_t buf_out_data;
  seg_word_t mirror_r;
  logic mirror_ok_r;

  seg_word_buffer u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(new_word),
    .in_ready(buf_in_ready),
    .in_data(shift_r),
    .out_valid(buf_out_valid),
    .out_ready(1'b1),
    .out_data(buf_out_data)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mirror_r <= '0;
      mirror_ok_r <= 1'b0;
    end else if (buf_out_valid) begin
      mirror_r <= buf_out_data;
      mirror_ok_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output latches
  seg_word_t latch_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      load_prev_r <= 1'b0;
    end else begin
      load_prev_r <= load_sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latch_r <= '0;
    end else if (mirror_ok_r && load_sync && !load_prev_r) begin
      // nothing is latched before the first word has arrived
      latch_r <= mirror_r;
    end else if (mirror_ok_r && load_sync) begin
      latch_r <= mirror_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // backplane: external, internal divide by 256, or static
  logic [`SEG_OSC_DIV_W-1:0] div_r;
  logic bp_int_r;
  logic bp_level;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_sync;
    end
  end

  // toggle every 128 oscillator edges: one backplane period per 256 cycles
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_r <= '0;
      bp_int_r <= 1'b0;
    end else if (osc_sync && !osc_prev_r) begin
      div_r <= div_r + `SEG_OSC_DIV_W'(1);
      if (div_r[`SEG_OSC_DIV_W-2:0] == '1) begin
        bp_int_r <= ~bp_int_r;
      end
    end
  end

  always_comb begin
    case (bp_source)
      BP_EXTERNAL: bp_level = ref_sync;
      BP_INTERNAL: bp_level = bp_int_r;
      BP_STATIC: bp_level = lvl_sync;
      default: bp_level = lvl_sync;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // segment drive: backplane and segments leave from the same edge
  seg_word_t seg_nxt;

  // a latched one drives its segment against the backplane
  for (genvar i = 0; i < `SEG_MAX_STAGES; i++) begin : g_seg
    assign seg_nxt[i] = latch_r[i] ^ bp_level;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      backplane_out <= 1'b0;
      segments <= '0;
    end else begin
      backplane_out <= bp_level;
      segments <= seg_nxt;
    end
  end
endmodule

// *** include/seg_driver_defines.svh ***
// constants for the serial segment display driver
`ifndef SEG_DRIVER_DEFINES_SVH
`define SEG_DRIVER_DEFINES_SVH
`define SEG_MAX_STAGES 38
`define SEG_LEN_30 30
`define SEG_LEN_32 32
`define SEG_LEN_38 38
`define SEG_OSC_DIV 256
`define SEG_OSC_DIV_W 8
`define SEG_SYS_CLK_MHZ 200
`define SEG_BUF_DEPTH 2
`endif

// *** include/seg_driver_pkg.sv ***
// types for the serial segment display driver
`include "seg_driver_defines.svh"
package seg_driver_pkg;
  typedef logic [`SEG_MAX_STAGES-1:0] seg_word_t;
  typedef enum logic [1:0] {
    BP_EXTERNAL,
    BP_INTERNAL,
    BP_STATIC
  } bp_source_e;
  typedef enum logic [1:0] {
    LEN_30,
    LEN_32,
    LEN_38
  } chain_len_e;
endpackage

// *** rtl/seg_word_buffer.sv ***
// two-entry valid/ready buffer for segment words
`timescale 1ns/100ps
`include "seg_driver_defines.svh"
module seg_word_buffer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire seg_driver_pkg::seg_word_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output seg_driver_pkg::seg_word_t out_data
);
  import seg_driver_pkg::*;

  seg_word_t mem_r [0:`SEG_BUF_DEPTH-1];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (do_rd) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 2'h1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule

// *** rtl/seg_sync2.sv ***
// two-flop level synchroniser into sys_clk
`timescale 1ns/100ps
module seg_sync2 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** verification/seg_host_model.sv ***
// host model for the serial shift lines
`timescale 1ns/100ps
module seg_host_model (
  output logic shift_clk,
  output logic data_in,
  output logic chip_sel_n
);
  initial {shift_clk, data_in, chip_sel_n} = 3'h5;
  // msb first, 30 ns a bit; clock idles high between frames
  task automatic frame(input logic [37:0] w, input logic sel_n);
    chip_sel_n = sel_n;
    for (int i = 37; i >= 0; i--) begin
      data_in = w[i];
      #15 shift_clk = 1'b0;
      #15 shift_clk = 1'b1;
    end
    data_in = ~data_in;
    chip_sel_n = 1'b1;
  endtask
endmodule

// *** verification/seg_driver_asserts.sv ***
// port assertions for the segment driver
`timescale 1ns/100ps
module seg_driver_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic data_in,
  input wire logic chip_sel_n,
  input wire logic load,
  input wire logic backplane_ref_in,
  input wire logic oscillator_option_pin,
  input wire seg_driver_pkg::bp_source_e bp_source,
  input wire seg_driver_pkg::chain_len_e chain_len,
  input wire logic bp_static_level,
  input wire logic data_out,
  input wire logic backplane_out,
  input wire seg_driver_pkg::seg_word_t segments
);
  import seg_driver_pkg::*;
  seg_word_t hist_r = '0;
  int cnt_r = 0;
  int osc_r = 0;
  int flips_r = 0;
  // selected shifts seen at the pins, newest in bit 0
  always_ff @(negedge shift_clk) begin
    if (!chip_sel_n) begin
      hist_r <= {hist_r[36:0], data_in};
      cnt_r <= cnt_r < 38 ? cnt_r + 1 : 38;
    end
  end
  always_ff @(posedge sys_clk) begin
    if ($changed(backplane_out)) osc_r <= 0;
    else if ($rose(oscillator_option_pin)) osc_r <= osc_r + 1;
  end
  always_ff @(posedge sys_clk) begin
    if (bp_source != BP_INTERNAL) flips_r <= 0;
    else if ($changed(backplane_out) && flips_r < 3) flips_r <= flips_r + 1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_lvl;
    (!load && bp_source == BP_STATIC && $stable(bp_static_level))[*6];
  endsequence
  sequence s_open;
    (load && bp_source == BP_STATIC && !bp_static_level && cnt_r == 38 && $stable(hist_r))[*8];
  endsequence
  chk_static_level: assert property ((bp_source == BP_STATIC && $stable(bp_static_level))[*4]
    |-> backplane_out == bp_static_level) else $error("static level");
  chk_ext_phase: assert property ((bp_source == BP_EXTERNAL && $stable(backplane_ref_in))[*8]
    |-> backplane_out == backplane_ref_in) else $error("phase");
  chk_latch_hold: assert property ((!load && $stable(backplane_out))[*8] |-> $stable(segments))
    else $error("hold");
  chk_level_flip: assert property (s_lvl ##1 $changed(bp_static_level) ##1 s_lvl
    |-> segments == ~$past(segments, 7)) else $error("invert");
  chk_open_latch: assert property (s_open ##1 s_open |-> segments == hist_r)
    else $error("transparent");
  chk_deselect_hold: assert property (chip_sel_n && cnt_r == 38 && $stable(chain_len)
    |-> $stable(data_out)) else $error("deselect");
  chk_tail_stage: assert property (cnt_r == 38 && $stable(hist_r)
    |-> data_out == hist_r[chain_len == LEN_30 ? 29 : chain_len == LEN_32 ? 31 : 37])
    else $error("tail");
  chk_osc_divide: assert property ($changed(backplane_out) && flips_r >= 2 |-> osc_r == 128)
    else $error("divide");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind serial_segment_display_driver seg_driver_asserts u_asserts (.*);

// *** verification/serial_segment_display_driver_bench.sv ***
// self-checking bench for the segment driver
`timescale 1ns/100ps
module serial_segment_display_driver_bench;
  import seg_driver_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, load = 1'b0, backplane_ref_in = 1'b0;
  logic oscillator_option_pin = 1'b0, bp_static_level = 1'b0;
  logic shift_clk, data_in, chip_sel_n, data_out, backplane_out;
  bp_source_e bp_source = BP_STATIC;
  chain_len_e chain_len = LEN_30;
  seg_word_t segments, w;
  realtime t0;
  int n_errors = 0, n_tests = 0, cycles = 0;
  seg_host_model u_host (.*);
  serial_segment_display_driver uut (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  initial forever #20 oscillator_option_pin = ~oscillator_option_pin;
  function automatic seg_word_t exp_seg(seg_word_t v, logic bp);
    return v ^ {38{bp}};
  endfunction
  task automatic check(seg_word_t seen, seg_word_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ticks(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic load_pulse();
    load = 1'b1;
    ticks(4);
    load = 1'b0;
    ticks(12);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hbda52884));
    ticks(8);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      chain_len = chain_len_e'(i);
      w = i == 0 ? '1 : seg_word_t'({$urandom, $urandom});
      u_host.frame(w, 1'b0);
      ticks(12);
      check(seg_word_t'(data_out), seg_word_t'(w[i == 0 ? 29 : i == 1 ? 31 : 37]));
      load_pulse();
      check(segments, exp_seg(w, 1'b0));
    end
    $display("shift tests done");
    u_host.frame(~w, 1'b0);
    ticks(16);
    check(segments, exp_seg(w, 1'b0));
    bp_static_level = 1'b1;
    ticks(10);
    check(segments, exp_seg(w, 1'b1));
    u_host.frame(seg_word_t'({$urandom, $urandom}), 1'b1);
    load_pulse();
    check(segments, w);
    $display("hold tests done");
    bp_static_level = 1'b0;
    load = 1'b1;
    w = seg_word_t'({$urandom, $urandom});
    u_host.frame(w, 1'b0);
    ticks(24);
    check(segments, w);
    load = 1'b0;
    bp_source = BP_EXTERNAL;
    repeat (6) begin
      backplane_ref_in = 1'($urandom);
      ticks(9);
      check(seg_word_t'(backplane_out), seg_word_t'(backplane_ref_in));
      check(segments, exp_seg(w, backplane_ref_in));
    end
    bp_source = BP_INTERNAL;
    repeat (3) @(backplane_out);
    t0 = $realtime;
    @(backplane_out);
    check(seg_word_t'(int'($realtime - t0)), 38'h1400);
    $display("backplane tests done");
    test_done();
  end
endmodule
